// *** rtl/tncr_regs.svh ***
// register offsets, field positions and reset values of the thermal bank
`ifndef TNCR_REGS_SVH
`define TNCR_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define TNCR_OFS_RESERVED_SLOT      8'h15
`define TNCR_OFS_DIE_TEMP_CTRL      8'h16
`define TNCR_OFS_THERM_CHG_ADJ      8'h17
`define TNCR_OFS_THERM_THRESH       8'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TNCR_RST_RESERVED_SLOT      8'h00
`define TNCR_RST_DIE_TEMP_CTRL      8'hc0
`define TNCR_RST_THERM_CHG_ADJ      8'h7a
`define TNCR_RST_THERM_THRESH       8'h54

// ----------------------------------------------------------------
// writable bit masks; all other positions are reserved
// ----------------------------------------------------------------
`define TNCR_WMASK_DIE_TEMP_CTRL    8'hfe
`define TNCR_WMASK_THERM_CHG_ADJ    8'hfe
`define TNCR_WMASK_THERM_THRESH     8'hff
// pulldown bits survive a watchdog expiry
`define TNCR_WDOG_KEEP_DIE_TEMP     8'h0e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TNCR_THERMAL_REGULATION_SELECT_HI                7
`define TNCR_THERMAL_REGULATION_SELECT_LO                6
`define TNCR_THERMAL_SHUTDOWN_SELECT_HI               5
`define TNCR_THERMAL_SHUTDOWN_SELECT_LO               4
`define TNCR_BUS_PD_BIT             3
`define TNCR_ALT1_PD_BIT            2
`define TNCR_ALT2_PD_BIT            1
`define TNCR_VSET_HI                7
`define TNCR_VSET_LO                5
`define TNCR_ISETH_HI               4
`define TNCR_ISETH_LO               3
`define TNCR_ISETC_HI               2
`define TNCR_ISETC_LO               1
`define TNCR_COOL_HI                7
`define TNCR_COOL_LO                6
`define TNCR_WARM_HI                5
`define TNCR_WARM_LO                4
`define TNCR_HOT_HI                 3
`define TNCR_HOT_LO                 2
`define TNCR_COLD_BIT               1
`define TNCR_IGNORE_BIT             0

`endif

// *** rtl/tncr_pkg.sv ***
// types shared by the thermal configuration bank
package tncr_pkg;

    // three-bit warm voltage reduction code
    typedef enum logic [2:0] {
        TNCR_VSET_SUSPEND = 3'h0,
        TNCR_VSET_M800    = 3'h1,
        TNCR_VSET_M600    = 3'h2,
        TNCR_VSET_M400    = 3'h3,
        TNCR_VSET_M300    = 3'h4,
        TNCR_VSET_M200    = 3'h5,
        TNCR_VSET_M100    = 3'h6,
        TNCR_VSET_KEEP    = 3'h7
    } tncr_vset_t;

    // two-bit current scale code, shared by warm and cool ranges
    typedef enum logic [1:0] {
        TNCR_ISET_SUSPEND = 2'h0,
        TNCR_ISET_PCT20   = 2'h1,
        TNCR_ISET_PCT40   = 2'h2,
        TNCR_ISET_KEEP    = 2'h3
    } tncr_iset_t;

    // supply-mode hot limit code
    typedef enum logic [1:0] {
        TNCR_HOT_P375 = 2'h0,
        TNCR_HOT_P342 = 2'h1,
        TNCR_HOT_P311 = 2'h2,
        TNCR_HOT_OFF  = 2'h3
    } tncr_hot_t;

endpackage

// *** rtl/tncr_decode.sv ***
// decodes the charge-adjust and supply-mode codes into enable flags and pass-through codes
`timescale 1ns/1ps

module tncr_decode (
    input  wire logic [2:0] vset_code,
    input  wire logic [1:0] iset_code,
    input  wire logic [1:0] hot_code,
    output logic            suspend,
    output logic [2:0]      vreduce_onehot_idx,
    output logic            vreduce_active,
    output logic [1:0]      iscale_pct_sel,
    output logic            hot_check_enable
);

    // ------------------------------------------------------------
    // voltage code: 000 suspends, 111 leaves target alone
    // ------------------------------------------------------------
    always_comb begin
        suspend            = 1'b0;
        vreduce_active     = 1'b0;
        vreduce_onehot_idx = 3'h0;
        unique case (tncr_pkg::tncr_vset_t'(vset_code))
            tncr_pkg::TNCR_VSET_SUSPEND: begin
                suspend = 1'b1;                       // see R6
            end
            tncr_pkg::TNCR_VSET_KEEP: begin
                vreduce_active = 1'b0;                // see R6
            end
            default: begin
                vreduce_active     = 1'b1;            // see R6
                vreduce_onehot_idx = vset_code;
            end
        endcase
        // current suspend joins the voltage suspend
        if (tncr_pkg::tncr_iset_t'(iset_code) ==
            tncr_pkg::TNCR_ISET_SUSPEND) begin
            suspend = 1'b1;                           // see R7
        end
    end

    // current code 01/10 select 20%/40%, 11 unchanged
    assign iscale_pct_sel   = iset_code;              // see R7
    // code 11 turns the hot check off
    assign hot_check_enable =
        (tncr_pkg::tncr_hot_t'(hot_code) != tncr_pkg::TNCR_HOT_OFF);

endmodule

// *** rtl/tncr_bank.sv ***
// thermal and thermistor configuration register bank
`timescale 1ns/1ps
`include "tncr_regs.svh"

// Contract
// R1: offset 0x15 is reserved, read-only, always reads zero.
// R2: thermal regulation select 60/80/100/120 C, default 11, reset or watchdog.
// R3: thermal shutdown select 150/130/120/85 C, default 00, reset or watchdog.
// R4: bus pulldown enable, default off, cleared by register reset only.
// R5: alternate input pulldown enables at bits 2 and 1, register reset only.
// R6: warm voltage code: 000 suspend, reductions, 111 unchanged, default 011.
// R7: warm current code: suspend, 20%, 40%, unchanged; default 11.
// R8: cool current code uses same encoding, default 01.
// R9: cool rising threshold select 71.7 to 62.9 percent, default 01.
// R10: warm falling threshold select 48.2 to 37.5 percent, default 01.
// R11: supply-mode hot limit 37.5/34.2/31.1 percent, 11 disables, default 01.
// R12: supply-mode cold limit 77.5 percent at 0, 80.4 percent at 1.
// R13: thermistor ignore forces temperature good, status bits held 0000.
// R14: reserved bits ignore writes and read back zero.
module tncr_bank (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reg_reset,
    input  wire logic       watchdog_expired,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            addr_hit,
    input  wire logic [3:0] temp_status_raw,
    input  wire logic       temp_good_raw,
    output logic [3:0]      temp_status,
    output logic            temp_good,
    output logic [1:0]      thermal_regulation_select,
    output logic [1:0]      thermal_shutdown_select,
    output logic            bus_pulldown_enable,
    output logic            alt_input_one_pulldown_enable,
    output logic            alt_input_two_pulldown_enable,
    output logic [2:0]      warm_voltage_reduction,
    output logic [1:0]      warm_current_scale,
    output logic [1:0]      cool_current_scale,
    output logic [1:0]      cool_rising_threshold,
    output logic [1:0]      warm_falling_threshold,
    output logic [1:0]      supply_mode_hot_limit,
    output logic            supply_mode_cold_limit,
    output logic            thermistor_ignore,
    output logic            warm_suspend,
    output logic            warm_vreduce_active,
    output logic            cool_suspend,
    output logic            supply_hot_check_enable
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] die_temp_reg;
    logic [7:0] chg_adj_reg;
    logic [7:0] thresh_reg;
    logic [7:0] rdata_next;
    logic       hit_next;
    logic       watchdog_only;

    // register reset takes precedence over a simultaneous watchdog
    assign watchdog_only = watchdog_expired & ~reg_reset;

    // die temperature control: pulldowns survive watchdog
    always_ff @(posedge clk) begin
        if (rst || reg_reset) begin
            die_temp_reg <= `TNCR_RST_DIE_TEMP_CTRL;  // see R2 see R3
        end else if (watchdog_only) begin
            // only regulation and shutdown selects go home; see R4 see R5
            die_temp_reg <= (die_temp_reg & `TNCR_WDOG_KEEP_DIE_TEMP) |
                            (`TNCR_RST_DIE_TEMP_CTRL &
                             ~`TNCR_WDOG_KEEP_DIE_TEMP);
        end else if (wr_en && addr == `TNCR_OFS_DIE_TEMP_CTRL) begin
            die_temp_reg <= wdata & `TNCR_WMASK_DIE_TEMP_CTRL; // see R14
        end
    end

    // charge adjust register: all fields reset by both causes
    always_ff @(posedge clk) begin
        if (rst || reg_reset || watchdog_expired) begin
            chg_adj_reg <= `TNCR_RST_THERM_CHG_ADJ;  // see R6 see R7 see R8
        end else if (wr_en && addr == `TNCR_OFS_THERM_CHG_ADJ) begin
            chg_adj_reg <= wdata & `TNCR_WMASK_THERM_CHG_ADJ; // see R14
        end
    end

    // thresholds register
    always_ff @(posedge clk) begin
        if (rst || reg_reset || watchdog_expired) begin
            thresh_reg <= `TNCR_RST_THERM_THRESH;    // see R9 see R10
        end else if (wr_en && addr == `TNCR_OFS_THERM_THRESH) begin
            thresh_reg <= wdata & `TNCR_WMASK_THERM_THRESH; // see R11
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reserved slot and bits are constant zero, no storage needed
    always_comb begin
        rdata_next = 8'h00;
        hit_next   = 1'b1;
        unique case (addr)
            `TNCR_OFS_RESERVED_SLOT: rdata_next = `TNCR_RST_RESERVED_SLOT;
            `TNCR_OFS_DIE_TEMP_CTRL: rdata_next = die_temp_reg;
            `TNCR_OFS_THERM_CHG_ADJ: rdata_next = chg_adj_reg;
            `TNCR_OFS_THERM_THRESH:  rdata_next = thresh_reg;
            default:                 hit_next   = 1'b0;
        endcase
    end

    // registered read data, one cycle after rd_en; see R1 see R14
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata    <= 8'h00;
            addr_hit <= 1'b0;
        end else if (rd_en) begin
            rdata    <= rdata_next;
            addr_hit <= hit_next;
        end
    end

    // ------------------------------------------------------------
    // field outputs
    // ------------------------------------------------------------
    assign thermal_regulation_select =
        die_temp_reg[`TNCR_THERMAL_REGULATION_SELECT_HI:`TNCR_THERMAL_REGULATION_SELECT_LO];     // see R2
    assign thermal_shutdown_select =
        die_temp_reg[`TNCR_THERMAL_SHUTDOWN_SELECT_HI:`TNCR_THERMAL_SHUTDOWN_SELECT_LO];   // see R3
    assign bus_pulldown_enable = die_temp_reg[`TNCR_BUS_PD_BIT]; // see R4
    assign alt_input_one_pulldown_enable =
        die_temp_reg[`TNCR_ALT1_PD_BIT];               // see R5
    assign alt_input_two_pulldown_enable =
        die_temp_reg[`TNCR_ALT2_PD_BIT];               // see R5
    assign warm_voltage_reduction =
        chg_adj_reg[`TNCR_VSET_HI:`TNCR_VSET_LO];
    assign warm_current_scale =
        chg_adj_reg[`TNCR_ISETH_HI:`TNCR_ISETH_LO];
    assign cool_current_scale =
        chg_adj_reg[`TNCR_ISETC_HI:`TNCR_ISETC_LO];    // see R8
    assign cool_rising_threshold =
        thresh_reg[`TNCR_COOL_HI:`TNCR_COOL_LO];       // see R9
    assign warm_falling_threshold =
        thresh_reg[`TNCR_WARM_HI:`TNCR_WARM_LO];       // see R10
    assign supply_mode_hot_limit =
        thresh_reg[`TNCR_HOT_HI:`TNCR_HOT_LO];         // see R11
    assign supply_mode_cold_limit = thresh_reg[`TNCR_COLD_BIT]; // see R12
    assign thermistor_ignore = thresh_reg[`TNCR_IGNORE_BIT];

    // ------------------------------------------------------------
    // thermistor ignore: force good, mask status
    // ------------------------------------------------------------
    // combinational so the override takes effect with the write
    assign temp_status = thermistor_ignore ? 4'h0 : temp_status_raw; // see R13
    assign temp_good   = thermistor_ignore | temp_good_raw;        // see R13

    // ------------------------------------------------------------
    // code decoders for warm and cool ranges
    // ------------------------------------------------------------
    // warm range uses voltage, current and the supply hot code
    tncr_decode u_warm_decode (
        .vset_code          (warm_voltage_reduction),
        .iset_code          (warm_current_scale),
        .hot_code           (supply_mode_hot_limit),
        .suspend            (warm_suspend),
        .vreduce_onehot_idx (),
        .vreduce_active     (warm_vreduce_active),
        .iscale_pct_sel     (),
        .hot_check_enable   (supply_hot_check_enable)
    );

    // cool range has no voltage code; feed "unchanged"
    tncr_decode u_cool_decode (
        .vset_code          (3'h7),
        .iset_code          (cool_current_scale),
        .hot_code           (2'h0),
        .suspend            (cool_suspend),
        .vreduce_onehot_idx (),
        .vreduce_active     (),
        .iscale_pct_sel     (),
        .hot_check_enable   ()
    );

endmodule

// *** test/tncr_bank_chk.sv ***
// assertion checker for the thermal configuration bank ports
`timescale 1ns/1ps

module tncr_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_reset,
    input wire logic       watchdog_expired,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] rdata,
    input wire logic       addr_hit,
    input wire logic [3:0] temp_status_raw,
    input wire logic       temp_good_raw,
    input wire logic [3:0] temp_status,
    input wire logic       temp_good,
    input wire logic [1:0] thermal_regulation_select,
    input wire logic [1:0] thermal_shutdown_select,
    input wire logic       bus_pulldown_enable,
    input wire logic       alt_input_one_pulldown_enable,
    input wire logic       alt_input_two_pulldown_enable,
    input wire logic [2:0] warm_voltage_reduction,
    input wire logic [1:0] warm_current_scale,
    input wire logic [1:0] cool_current_scale,
    input wire logic [1:0] cool_rising_threshold,
    input wire logic [1:0] warm_falling_threshold,
    input wire logic [1:0] supply_mode_hot_limit,
    input wire logic       supply_mode_cold_limit,
    input wire logic       thermistor_ignore,
    input wire logic       warm_suspend,
    input wire logic       warm_vreduce_active,
    input wire logic       cool_suspend,
    input wire logic       supply_hot_check_enable
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // either default source, a write in the same cycle loses
    sequence s_any_rst;
        reg_reset || watchdog_expired;
    endsequence
    // watchdog alone, so pulldowns must not move
    sequence s_wdog_only;
        watchdog_expired && !reg_reset && !wr_en;
    endsequence

    a_die_defaults: assert property (
        s_any_rst |=> thermal_regulation_select == 2'h3 &&
                      thermal_shutdown_select == 2'h0)
        else $error("die thresholds not back at default");
    a_chg_defaults: assert property (
        s_any_rst |=> warm_voltage_reduction == 3'h3 &&
                      warm_current_scale == 2'h3)
        else $error("warm charge codes not back at default");
    a_pd_regrst: assert property (
        reg_reset |=> {bus_pulldown_enable, alt_input_one_pulldown_enable,
                       alt_input_two_pulldown_enable} == 3'h0)
        else $error("pulldown survived register reset");
    a_pd_wdog_keep: assert property (
        s_wdog_only |=> $stable({bus_pulldown_enable,
            alt_input_one_pulldown_enable, alt_input_two_pulldown_enable}))
        else $error("watchdog changed a pulldown");
    a_rsvd_reads_zero: assert property (
        rd_en && addr == 8'h15 |=> rdata == 8'h00 && addr_hit)
        else $error("reserved slot read not zero");
    a_rsvd_bit_zero: assert property (
        rd_en && (addr == 8'h16 || addr == 8'h17) |=> rdata[0] == 1'b0)
        else $error("reserved bit read back nonzero");
    a_ignore_forces: assert property (
        thermistor_ignore |-> temp_status == 4'h0 && temp_good)
        else $error("ignore did not force good status");
    a_ignore_off: assert property (
        !thermistor_ignore |-> temp_status == temp_status_raw &&
                               temp_good == temp_good_raw)
        else $error("status not passed through");
    a_warm_suspend: assert property (
        warm_suspend == (warm_voltage_reduction == 3'h0 ||
                         warm_current_scale == 2'h0))
        else $error("warm suspend decode wrong");
    a_thr_defaults: assert property (
        s_any_rst |=> cool_current_scale == 2'h1 &&
                      cool_rising_threshold == 2'h1 &&
                      warm_falling_threshold == 2'h1 &&
                      supply_mode_hot_limit == 2'h1 &&
                      !supply_mode_cold_limit && !thermistor_ignore)
        else $error("threshold codes not back at default");
    a_hot_disable: assert property (
        supply_hot_check_enable == (supply_mode_hot_limit != 2'h3))
        else $error("hot check enable decode wrong");
    a_cool_suspend: assert property (
        cool_suspend == (cool_current_scale == 2'h0))
        else $error("cool suspend decode wrong");
    a_vreduce_active: assert property (
        warm_vreduce_active == (warm_voltage_reduction != 3'h0 &&
                                warm_voltage_reduction != 3'h7))
        else $error("voltage reduction decode wrong");
endmodule

bind tncr_bank tncr_chk u_chk (.*);

// *** test/tb_thermal_ntc_config_regs.sv ***
// self-checking bench for the thermal configuration bank
`timescale 1ns/1ps

module tb_thermal_ntc_config_regs;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} tncr_row_t;
    // ----------------------------------------------------------------
    // signals, table and tasks
    // ----------------------------------------------------------------
    logic       clk, rst, reg_reset, watchdog_expired, wr_en, rd_en;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] temp_status_raw, temp_status;
    logic       temp_good_raw, temp_good, warm_suspend, addr_hit;
    logic [2:0] warm_voltage_reduction;
    int         compares, miscompares;
    // reserved slot, masked bit 0, full register, clearing, unmapped
    tncr_row_t  rows [8] = '{'{8'h15, 8'hff, 8'h00}, '{8'h16, 8'hff, 8'hfe},
        '{8'h17, 8'hff, 8'hfe}, '{8'h18, 8'hff, 8'hff},
        '{8'h16, 8'h01, 8'h00}, '{8'h17, 8'h01, 8'h00},
        '{8'h18, 8'h00, 8'h00}, '{8'h40, 8'hff, 8'h00}};

    tncr_bank dut (.clk(clk), .rst(rst), .reg_reset(reg_reset),
        .watchdog_expired(watchdog_expired), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata), .addr_hit(addr_hit),
        .temp_status_raw(temp_status_raw), .temp_good_raw(temp_good_raw),
        .temp_status(temp_status), .temp_good(temp_good),
        .thermal_regulation_select(), .thermal_shutdown_select(),
        .bus_pulldown_enable(), .alt_input_one_pulldown_enable(),
        .alt_input_two_pulldown_enable(),
        .warm_voltage_reduction(warm_voltage_reduction),
        .warm_current_scale(), .cool_current_scale(),
        .cool_rising_threshold(), .warm_falling_threshold(),
        .supply_mode_hot_limit(), .supply_mode_cold_limit(),
        .thermistor_ignore(), .warm_suspend(warm_suspend),
        .warm_vreduce_active(), .cool_suspend(),
        .supply_hot_check_enable());

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // inputs move on the falling edge, away from the sampling edge
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk) {wr_en, addr, wdata} = {1'b1, a, d};
        @(negedge clk) wr_en = 1'b0;
    endtask

    // extra cycle is harmless: rdata holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) {rd_en, addr} = {1'b1, a};
        @(negedge clk) rd_en = 1'b0;
        @(negedge clk) d = rdata;
    endtask

    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, reg_reset, watchdog_expired, wr_en, rd_en} = 5'h10;
        {addr, wdata, temp_status_raw, temp_good_raw} = 21'h0000a << 1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd(8'h16, v); chk("die reset", v, 8'hc0);
        rd(8'h17, v); chk("adj reset", v, 8'h7a);
        rd(8'h18, v); chk("thr reset", v, 8'h54);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("row readback", v, rows[i].e);
            chk("row hit", {7'h0, addr_hit},
                {7'h0, rows[i].a inside {[8'h15:8'h18]}});
        end
        // watchdog restores all but the pulldowns
        wr(8'h16, 8'hff); wr(8'h17, 8'h00); wr(8'h18, 8'hff);
        @(negedge clk) watchdog_expired = 1'b1;
        @(negedge clk) watchdog_expired = 1'b0;
        rd(8'h16, v); chk("die wdog", v, 8'hce);
        rd(8'h17, v); chk("adj wdog", v, 8'h7a);
        rd(8'h18, v); chk("thr wdog", v, 8'h54);
        wr(8'h18, 8'hff);
        @(negedge clk) reg_reset = 1'b1;
        @(negedge clk) reg_reset = 1'b0;
        rd(8'h16, v); chk("die regrst", v, 8'hc0);
        rd(8'h18, v); chk("thr regrst", v, 8'h54);
        wr(8'h18, 8'h01);
        chk("status ign", {4'h0, temp_status}, 8'h00);
        chk("good ign", {7'h0, temp_good}, 8'h01);
        wr(8'h18, 8'h00);
        chk("status raw", {4'h0, temp_status}, 8'h0a);
        // every voltage code, warm current codes cycled alongside
        for (int i = 0; i < 8; i++) begin
            wr(8'h17, {i[2:0], i[1:0], 3'h2});
            chk("vset", {5'h0, warm_voltage_reduction}, i[7:0]);
            chk("suspend", {7'h0, warm_suspend},
                {7'h0, i == 0 || i[1:0] == 2'h0});
        end
        // mid-run reset must bring the written registers home
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        rd(8'h17, v); chk("adj rst", v, 8'h7a);
        rd(8'h18, v); chk("thr rst", v, 8'h54);
        complete_run;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run;
    end
endmodule
